// File: src/ebr_pkg.sv
// Shared types and constants for the external bus cycle controller
package ebr_pkg;

  // Bus and counter widths
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 16;
  localparam int CNT_W   = 5;
  localparam int LEN_W   = 8;

  // One bus clock unit lasts this many system clocks (reference clock is a divide by two)
  localparam int UNIT_CYC = 2;

  // Longest gap from end of address phase to strobe: command delay 3 plus write setup 1 units
  localparam int GAP_MAX_CYC = 8;

  // Reset values of the bus pins, and the counter decrement step
  localparam logic              STROBE_IDLE = 1'b1;
  localparam logic              CS_IDLE     = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST    = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 5'h01;

  // Cycle phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_WDS  = 3'b011,
    ST_ACC  = 3'b100,
    ST_RDY  = 3'b101,
    ST_HOLD = 3'b110
  } ebr_state_type;

  // Phase timing configuration; lengths in bus clock units
  typedef struct packed {
    logic       ab_ext;     // Address setup: 0 gives 1 unit, 1 gives 2
    logic [1:0] cmd_len;    // Command delay 0..3
    logic       wds_len;    // Write data setup / tristate 0..1
    logic [4:0] acc_len;    // Access phase minus one: 0..31 gives 1..32
    logic [1:0] hold_len;   // Hold 0..3
    logic       rdy_en;     // Access phase extended by handshake
    logic       rdy_async;  // Handshake through synchroniser
    logic       rdy_pol;    // Active level of handshake
  } ebr_cfg_type;

  // Latched bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              multiplexed_mode;
    logic              upper;
  } ebr_req_type;

endpackage

// File: src/ebr_bus_ctrl.sv
// External bus cycle controller with programmable phases and ready handshake
`timescale 1ns/1ps
module ebr_bus_ctrl
  import ebr_pkg::*;
(
  input  wire logic              SYS_CLK_I,    // System clock, 100 MHz
  input  wire logic              RST_I,        // Synchronous reset, active high
  input  wire logic              LINK_CLK_I,   // Clock of the external module's handshake logic
  input  wire logic              START_I,      // Request pulse, taken while idle
  input  wire ebr_req_type       REQ_I,        // Request contents, read with START_I
  input  wire ebr_cfg_type       PHASE_CFG_I,  // Phase timing configuration, read with START_I
  input  wire logic              READY_PIN_I,  // Handshake pin
  input  wire logic [DATA_W-1:0] DATA_IN_I,    // Separate data bus, input side
  input  wire logic [DATA_W-1:0] MUXED_IN_I,   // Multiplexed bus, input side
  output logic                   BUSY_O,       // Request pending or cycle running
  output logic                   DONE_O,       // Cycle finished pulse
  output logic [DATA_W-1:0]      RDATA_O,      // Captured read data
  output logic                   BUS_CLK_O,    // Bus reference clock
  output logic [ADDR_W-1:0]      ADDR_O,       // Address bus
  output logic [DATA_W-1:0]      DATA_OUT_O,   // Separate data bus, output side
  output logic                   DATA_OE_O,    // Separate data bus drive enable
  output logic [DATA_W-1:0]      MUXED_OUT_O,  // Multiplexed bus, output side
  output logic                   MUXED_OE_O,   // Multiplexed bus drive enable
  output logic                   ALE_O,        // Address latch enable
  output logic                   RD_N_O,       // Read strobe, active low
  output logic                   WR_N_O,       // Write strobe, active low
  output logic                   CS_N_O,       // Chip select, active low
  output logic                   UPPER_BYTE_SEL_O // Upper byte select
);

  ebr_state_type    state;
  ebr_state_type    next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_busy;
  logic             finish;
  logic             pend;
  ebr_req_type      req;
  ebr_cfg_type      cfg;
  logic             tick;
  logic             rdy_link;
  logic             rdy_s1;
  logic             rdy_s2;
  logic             link_rst_s1;
  logic             link_rst;
  logic             rdy_ok;
  logic             strobe_next;
  logic [DATA_W-1:0] rd_pin;

  // Bus reference clock is a divide by two; one unit is one of its periods
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      BUS_CLK_O <= 1'b0;
    end else begin
      BUS_CLK_O <= ~BUS_CLK_O;
    end
  end

  // Phases advance on the edge where the reference clock falls
  assign tick = BUS_CLK_O;

  // Reset brought into the link domain
  always_ff @(posedge LINK_CLK_I) begin
    link_rst_s1 <= RST_I;
    link_rst    <= link_rst_s1;
  end

  // Handshake pin registered by the external module's own clock
  always_ff @(posedge LINK_CLK_I) begin
    if (link_rst) begin
      rdy_link <= 1'b0;
    end else begin
      rdy_link <= READY_PIN_I;
    end
  end

  // Two-stage crossing into the system domain; costs the extra wait state
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      rdy_s1 <= rdy_link;
      rdy_s2 <= rdy_s1;
    end
  end

  // Synchronous mode reads the pin as is for the shortest cycle; polarity applied last
  assign rdy_ok = cfg.rdy_async ? (rdy_s2 == cfg.rdy_pol)
                                : (READY_PIN_I == cfg.rdy_pol);

  // Request and its timing are latched so the sample point belongs to this cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pend <= 1'b0;
      req  <= '0;
      cfg  <= '0;
    end else if (START_I && !BUSY_O) begin
      pend <= 1'b1;
      req  <= REQ_I;
      cfg  <= PHASE_CFG_I;
    end else if (tick && state == ST_IDLE) begin
      pend <= 1'b0;
    end
  end

  // Phase sequencing; empty phases are skipped
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    finish     = 1'b0;
    if (tick) begin
      unique case (state)
        ST_IDLE: begin
          if (pend) begin
            next_state = ST_ADDR;
            next_cnt   = {{(CNT_W-1){1'b0}}, cfg.ab_ext};
          end
        end
        ST_ADDR: begin
          if (cnt != '0) begin
            next_cnt = cnt - CNT_ONE;
          end else if (cfg.cmd_len != '0) begin
            next_state = ST_CMD;
            next_cnt   = CNT_W'(cfg.cmd_len) - CNT_ONE;
          end else if (cfg.wds_len) begin
            next_state = ST_WDS;
            next_cnt   = '0;
          end else begin
            next_state = ST_ACC;
            next_cnt   = cfg.acc_len;
          end
        end
        ST_CMD: begin
          if (cnt != '0) begin
            next_cnt = cnt - CNT_ONE;
          end else if (cfg.wds_len) begin
            next_state = ST_WDS;
            next_cnt   = '0;
          end else begin
            next_state = ST_ACC;
            next_cnt   = cfg.acc_len;
          end
        end
        ST_WDS: begin
          next_state = ST_ACC;
          next_cnt   = cfg.acc_len;
        end
        ST_ACC: begin
          if (cnt != '0) begin
            next_cnt = cnt - CNT_ONE;
          end else if (!cfg.rdy_en) begin
            finish = 1'b1;
          end else if (cfg.rdy_async) begin
            next_state = ST_RDY;
          end else if (rdy_ok) begin
            finish = 1'b1;
          end else begin
            next_state = ST_RDY;
          end
        end
        ST_RDY: begin
          if (rdy_ok) begin
            finish = 1'b1;
          end
        end
        ST_HOLD: begin
          if (cnt != '0) begin
            next_cnt = cnt - CNT_ONE;
          end else begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      if (finish) begin
        if (cfg.hold_len != '0) begin
          next_state = ST_HOLD;
          next_cnt   = CNT_W'(cfg.hold_len) - CNT_ONE;
        end else begin
          next_state = ST_IDLE;
        end
      end
    end
  end

  // Phase state and counter
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign strobe_next = (next_state == ST_ACC) || (next_state == ST_RDY);
  assign next_busy   = (next_state != ST_IDLE) || pend || (START_I && !BUSY_O);
  assign rd_pin      = req.multiplexed_mode ? MUXED_IN_I : DATA_IN_I;

  // Bus pins registered from the next phase so they switch with it
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      CS_N_O           <= CS_IDLE;
      ALE_O            <= 1'b0;
      RD_N_O           <= STROBE_IDLE;
      WR_N_O           <= STROBE_IDLE;
      ADDR_O           <= ADDR_RST;
      UPPER_BYTE_SEL_O <= 1'b0;
      MUXED_OUT_O      <= DATA_RST;
      MUXED_OE_O       <= 1'b0;
      DATA_OUT_O       <= DATA_RST;
      DATA_OE_O        <= 1'b0;
    end else begin
      CS_N_O <= (next_state == ST_IDLE);
      ALE_O  <= (next_state == ST_ADDR);
      RD_N_O <= ~(strobe_next && !req.write);
      WR_N_O <= ~(strobe_next && req.write);
      if (next_state == ST_ADDR) begin
        ADDR_O           <= req.addr;
        UPPER_BYTE_SEL_O <= req.upper;
      end
      // Address first, then write data; reads release the lines after the command delay
      if (next_state == ST_ADDR || next_state == ST_CMD) begin
        MUXED_OUT_O <= req.addr[DATA_W-1:0];
        MUXED_OE_O  <= req.multiplexed_mode;
      end else begin
        MUXED_OUT_O <= req.wdata;
        MUXED_OE_O  <= req.multiplexed_mode && req.write && (next_state != ST_IDLE);
      end
      DATA_OUT_O <= req.wdata;
      DATA_OE_O  <= !req.multiplexed_mode && req.write && (next_state inside {ST_WDS, ST_ACC, ST_RDY, ST_HOLD});
    end
  end

  // Read data taken on the edge that raises the read strobe; the address is not used
  // here, so moving it early cannot disturb the captured word
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RDATA_O <= DATA_RST;
      DONE_O  <= 1'b0;
      BUSY_O  <= 1'b0;
    end else begin
      BUSY_O <= next_busy;
      DONE_O <= finish;
      if (finish && !req.write) begin
        RDATA_O <= rd_pin;
      end
    end
  end

  // Helper: cycles the strobe has been low
  logic [LEN_W-1:0] strobe_len;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || (RD_N_O && WR_N_O)) begin
      strobe_len <= '0;
    end else if (strobe_len != '1) begin
      strobe_len <= strobe_len + 8'h01;
    end
  end

  sequence s_addr_end;
    $fell(ALE_O) && !CS_N_O;
  endsequence
  sequence s_strobe_soon;
    ##[0:8] (!RD_N_O || !WR_N_O);
  endsequence

  property p_phase_order;
    @(posedge SYS_CLK_I) disable iff (RST_I) s_addr_end |-> s_strobe_soon;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("strobe late after address phase");

  property p_acc_min;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      $rose(RD_N_O & WR_N_O) |-> (strobe_len >= LEN_W'((cfg.acc_len + 6'h01) * UNIT_CYC));
  endproperty
  a_acc_min: assert property (p_acc_min) else $error("access phase too short");

  property p_mux_data;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      (!WR_N_O && req.multiplexed_mode) |-> (MUXED_OE_O && MUXED_OUT_O == req.wdata);
  endproperty
  a_mux_data: assert property (p_mux_data) else $error("muxed write data missing");

  property p_separate_bus_mode_data;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      (!WR_N_O && !req.multiplexed_mode) |-> (DATA_OE_O && DATA_OUT_O == req.wdata && !MUXED_OE_O);
  endproperty
  a_separate_bus_mode_data: assert property (p_separate_bus_mode_data) else $error("separate write data missing");

  property p_rd_capture;
    @(posedge SYS_CLK_I) disable iff (RST_I) $rose(RD_N_O) |-> (RDATA_O == $past(rd_pin));
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read data not from strobe edge");

  property p_async_wait;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      ($rose(RD_N_O & WR_N_O) && cfg.rdy_en && cfg.rdy_async)
        |-> (strobe_len >= LEN_W'((cfg.acc_len + 6'h02) * UNIT_CYC));
  endproperty
  a_async_wait: assert property (p_async_wait) else $error("async handshake without wait state");

  property p_not_ready;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      (state == ST_RDY && tick && !rdy_ok) |=> (state == ST_RDY) ##1 (state == ST_RDY);
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("wait state not inserted");

  property p_ready_end;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      (state == ST_RDY && tick && rdy_ok) |=> (RD_N_O && WR_N_O && DONE_O);
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("cycle not ended on handshake");

  property p_sync_point;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      (state == ST_ACC && tick && cnt == '0 && cfg.rdy_en && !cfg.rdy_async && rdy_ok)
        |=> (state != ST_RDY && DONE_O);
  endproperty
  a_sync_point: assert property (p_sync_point) else $error("sync handshake point missed");

  property p_cs_hold;
    @(posedge SYS_CLK_I) disable iff (RST_I) (!RD_N_O || !WR_N_O || ALE_O) |-> !CS_N_O;
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("chip select dropped in cycle");

endmodule

// File: bench/ebr_mem_model.sv
// Behavioural external memory answering bus cycles with a ready handshake
`timescale 1ns/1ps
module ebr_mem_model
  import ebr_pkg::*;
(
  input  wire logic              bus_clk_i,  // Bus reference clock
  input  wire logic              sys_clk_i,  // System clock
  input  wire logic              link_clk_i, // Clock of async ready
  input  wire logic [5:0]        wait_i,     // Units before ready
  input  wire logic              pol_i,      // Ready active level
  input  wire logic              async_i,    // Ready from link clock
  input  wire logic [ADDR_W-1:0] addr_i,     // Address bus
  input  wire logic [DATA_W-1:0] mout_i,     // Muxed bus, device side
  input  wire logic              moe_i,      // Muxed bus enable
  input  wire logic              ale_i,      // Address latch enable
  input  wire logic              rd_n_i,     // Read strobe
  input  wire logic              wr_n_i,     // Write strobe
  output logic                   ready_o,    // Ready pin
  output logic [DATA_W-1:0]      din_o,      // Separate data bus
  output logic [DATA_W-1:0]      min_o       // Muxed bus wire
);
  logic [DATA_W-1:0] lat = 16'h0000;
  logic [DATA_W-1:0] word;
  logic              is_mux = 1'b0;
  logic              rdy_b = 1'b0;
  logic              rdy_l = 1'b0;
  logic [5:0]        cnt = 6'h00;
  assign word = lat ^ 16'h5a3c;
  // Latch address and bus mode while the latch enable is up
  always @(posedge sys_clk_i) begin
    if (ale_i) begin
      lat <= moe_i ? mout_i : addr_i[DATA_W-1:0];
      is_mux <= moe_i;
    end
  end
  // Word only while strobe low; inverse after, so a late capture shows up
  assign din_o = (!rd_n_i && !is_mux) ? word : ~word;
  assign min_o = moe_i ? mout_i : ((!rd_n_i && is_mux) ? word : ~word);
  // Count reference clock rises inside the strobe, drop ready once it ends
  always @(posedge bus_clk_i) begin
    if (rd_n_i && wr_n_i) begin
      cnt <= 6'h00;
      rdy_b <= 1'b0;
    end else begin
      cnt <= cnt + 6'h01;
      rdy_b <= ((cnt + 6'h01) >= wait_i);
    end
  end
  // Async copy is held until the strobe ends, well over one period
  always @(posedge link_clk_i) begin
    rdy_l <= rdy_b;
  end
  assign ready_o = (async_i ? rdy_l : rdy_b) ~^ pol_i;
endmodule

// File: bench/external_bus_ready_control_test.sv
// Self-checking bench for the external bus cycle controller
`timescale 1ns/1ps
module external_bus_ready_control_test
  import ebr_pkg::*;
();
  logic              clk = 1'b0;
  logic              link = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  ebr_req_type       req = '0;
  ebr_cfg_type       cfg = '0;
  logic [5:0]        m_wait = 6'h00;
  logic              m_pol = 1'b1;
  logic              m_async = 1'b0;
  logic              rdy, busy, done, bclk, doe, moe, ale, rd_n, wr_n, cs_n, ubs;
  logic [DATA_W-1:0] rdata, din, dout, min, mout;
  logic [ADDR_W-1:0] addr;
  int                mismatches = 0;
  int                num_checks = 0;
  int                cycles = 0;

  // Link clock is free running and drifts against the system clock
  always #5 clk = ~clk;
  always #6 link = ~link;

  ebr_bus_ctrl u_dut (.SYS_CLK_I(clk), .RST_I(rst), .LINK_CLK_I(link), .START_I(start), .REQ_I(req),
    .PHASE_CFG_I(cfg), .READY_PIN_I(rdy), .DATA_IN_I(din), .MUXED_IN_I(min), .BUSY_O(busy),
    .DONE_O(done), .RDATA_O(rdata), .BUS_CLK_O(bclk), .ADDR_O(addr), .DATA_OUT_O(dout),
    .DATA_OE_O(doe), .MUXED_OUT_O(mout), .MUXED_OE_O(moe), .ALE_O(ale), .RD_N_O(rd_n),
    .WR_N_O(wr_n), .CS_N_O(cs_n), .UPPER_BYTE_SEL_O(ubs));

  ebr_mem_model u_mem (.bus_clk_i(bclk), .sys_clk_i(clk), .link_clk_i(link), .wait_i(m_wait),
    .pol_i(m_pol), .async_i(m_async), .addr_i(addr), .mout_i(mout), .moe_i(moe), .ale_i(ale),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .ready_o(rdy), .din_o(din), .min_o(min));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Lead nibble is {ab_ext, cmd_len, wds_len}; rdy is {en, async, pol}
  function automatic ebr_cfg_type mk(input logic [3:0] lead, input logic [4:0] acc,
                                    input logic [1:0] hold, input logic [2:0] rdy3);
    return {lead, acc, hold, rdy3};
  endfunction

  // Mode bits are {write, mux, upper}
  function automatic ebr_req_type rq(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                    input logic [2:0] m);
    return {a, d, m};
  endfunction

  // One whole cycle; a second start mid-cycle must be ignored
  task automatic run(input ebr_req_type r, input ebr_cfg_type c, input logic again, output int stb);
    int   cs, tot, at, ales, fix;
    logic ale_q, bclk_q;
    cs = 0;
    tot = 0;
    at = 0;
    ales = 0;
    stb = 0;
    ale_q = 1'b0;
    bclk_q = 1'b0;
    fix = 2 * (int'(c.ab_ext) + 1 + int'(c.cmd_len) + int'(c.wds_len));
    @(negedge clk);
    req = r;
    cfg = c;
    start = 1'b1;
    do begin
      @(negedge clk);
      tot++;
      start = again && tot == 3;
      // Reference clock must toggle every system cycle; one unit is two cycles
      if (tot > 1) chk(bclk, !bclk_q);
      bclk_q = bclk;
      if (ale === 1'b1 && !ale_q) ales++;
      ale_q = ale;
      if (ale === 1'b1 && r.multiplexed_mode) chk(mout, r.addr[DATA_W-1:0]);
      if (cs_n === 1'b0) cs++;
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        stb++;
        if (stb == 1) chk(ubs, r.upper);
        if (stb == 1) chk(addr, r.addr);
        if (stb == 1) chk(r.multiplexed_mode ? moe : doe, r.write);
        if (stb == 1 && r.write) chk(r.multiplexed_mode ? mout : dout, r.wdata);
      end
      if (done === 1'b1) at = tot;
    end while (busy === 1'b1 && tot < 400);
    chk(ales, 1);
    chk(cs, stb + fix + 2 * int'(c.hold_len));
    // Take edge, then one or two edges until the reference clock next falls
    chk(((at - stb - fix) inside {2, 3}), 1);
  endtask

  task automatic t_read_separate_bus_mode;
    int s;
    run(rq(24'h0a1234, 16'h0000, 3'b001), mk(4'h0, 5'h00, 2'h0, 3'b000), 1'b0, s);
    chk(s, 2);
    chk(rdata, 16'h1234 ^ 16'h5a3c);
  endtask

  task automatic t_read_mux_long;
    int s;
    run(rq(24'h00beef, 16'h0000, 3'b010), mk(4'hf, 5'h1f, 2'h3, 3'b000), 1'b0, s);
    chk(s, 64);
    chk(rdata, 16'hbeef ^ 16'h5a3c);
  endtask

  task automatic t_writes;
    int s;
    run(rq(24'h00c0de, 16'h9a7b, 3'b110), mk(4'h6, 5'h02, 2'h1, 3'b000), 1'b1, s);
    chk(s, 6);
    run(rq(24'h3f0011, 16'h4c2d, 3'b101), mk(4'h3, 5'h01, 2'h2, 3'b000), 1'b0, s);
    chk(s, 4);
  endtask

  // Ready late: each inactive sample adds exactly one unit
  task automatic t_sync_wait;
    int s;
    m_wait = 6'h04;
    run(rq(24'h000777, 16'h0000, 3'b000), mk(4'h0, 5'h00, 2'h0, 3'b101), 1'b0, s);
    chk(s, 8);
    chk(rdata, 16'h0777 ^ 16'h5a3c);
  endtask

  // Ready already active: mandatory units still run out first
  task automatic t_sync_early;
    int s;
    m_wait = 6'h00;
    run(rq(24'h000100, 16'h0000, 3'b000), mk(4'h0, 5'h02, 2'h0, 3'b101), 1'b0, s);
    chk(s, 6);
  endtask

  task automatic t_pol_low;
    int s;
    m_pol = 1'b0;
    m_wait = 6'h03;
    run(rq(24'h000200, 16'h1357, 3'b100), mk(4'h0, 5'h01, 2'h0, 3'b100), 1'b0, s);
    chk(s, 6);
  endtask

  // Handshake disabled: a ready that never comes must not stretch the cycle
  task automatic t_rdy_off;
    int s;
    m_pol = 1'b1;
    m_wait = 6'h09;
    run(rq(24'h000300, 16'h0000, 3'b000), mk(4'h0, 5'h01, 2'h0, 3'b001), 1'b0, s);
    chk(s, 4);
  endtask

  task automatic t_async;
    int s;
    m_async = 1'b1;
    m_wait = 6'h00;
    run(rq(24'h000400, 16'h0000, 3'b000), mk(4'h0, 5'h00, 2'h0, 3'b111), 1'b0, s);
    chk((s >= 4 && s <= 8), 1);
    m_pol = 1'b0;
    m_wait = 6'h03;
    run(rq(24'h000500, 16'h2468, 3'b100), mk(4'h0, 5'h00, 2'h0, 3'b110), 1'b0, s);
    chk((s >= 6 && s <= 12), 1);
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_read_separate_bus_mode();
    t_read_mux_long();
    t_writes();
    t_sync_wait();
    t_sync_early();
    t_pol_low();
    t_rdy_off();
    t_async();
    tally_and_finish();
  end
endmodule
